/* rtl/torque_cond_pkg.sv */
// Shared constants and carriers for the torque command conditioning block.
// Assumes one system clock; parameter indices are local to this block.
package torque_cond_pkg;
    // ==========================================
    // Parameter store layout
    localparam int N_REGS = 16;
    localparam int N_CH = 2;
    localparam logic [3:0] CH_STRIDE = 4'h4;
    localparam logic [3:0] CH_OFFSET = 4'h0;
    localparam logic [3:0] CH_FILTER = 4'h1;
    localparam logic [3:0] CH_DEADBAND = 4'h2;
    localparam logic [3:0] CH_ZERO_DRIFT = 4'h3;
    localparam logic [3:0] REG_FULL_SCALE = 4'h8;
    localparam logic [3:0] REG_AUTO_CAL = 4'h9;
    localparam logic [3:0] REG_TORQUE_SRC = 4'ha;
    localparam logic [3:0] REG_MAIN_SRC = 4'hb;
    localparam logic [3:0] REG_AUX_SRC = 4'hc;
    localparam logic [3:0] REG_INTERNAL = 4'hd;
    localparam logic [3:0] REG_ROT_DIR = 4'he;
    localparam logic [3:0] REG_COMM_TORQUE = 4'hf;
    // Entries writable only while stopped
    localparam logic [15:0] STOP_ONLY_MASK = 16'h5f00;
    // ==========================================
    // Values after reset
    localparam logic [31:0] FILTER_RESET = 32'h0000_00c8;
    localparam logic [31:0] DEADBAND_RESET = 32'h0000_0064;
    localparam logic [31:0] FULL_SCALE_RESET = 32'h0000_0064;
    localparam logic [31:0] REG_RESET [N_REGS] = '{
        32'h0, FILTER_RESET, DEADBAND_RESET, 32'h0,
        32'h0, FILTER_RESET, DEADBAND_RESET, 32'h0,
        FULL_SCALE_RESET, 32'h0, 32'h0, 32'h0,
        32'h0, 32'h0, 32'h0, 32'h0};
    // ==========================================
    // Selector codes
    localparam logic [2:0] SRC_MAIN = 3'h0;
    localparam logic [2:0] SRC_AUX = 3'h1;
    localparam logic [2:0] SRC_SUM = 3'h2;
    localparam logic [2:0] SRC_SWITCH = 3'h3;
    localparam logic [2:0] SRC_COMM = 3'h4;
    localparam logic [1:0] SEL_INTERNAL = 2'h0;
    localparam logic [1:0] SEL_FIRST = 2'h1;
    localparam logic [1:0] SEL_SECOND = 2'h2;
    localparam logic [1:0] CAL_FIRST = 2'h1;
    localparam logic [1:0] CAL_SECOND = 2'h2;
    // ==========================================
    // Scaling (voltages in 0.1 mV, torque in 0.001 % rated)
    localparam logic signed [31:0] SPAN_LIMIT = 32'sh0001_86a0;
    localparam logic signed [31:0] TORQUE_LIMIT = 32'sh000c_3500;
    localparam logic signed [31:0] DRIFT_LIMIT = 32'sh0000_1388;
    localparam logic signed [31:0] OFFSET_TO_TENTH = 32'sh0000_000a;
    localparam logic signed [31:0] TORQUE_DIV = 32'sh0000_0064;
    localparam logic signed [31:0] INTERNAL_TO_MILLI = 32'sh0000_0064;
    localparam int FIFO_WORDS = 4;
    // ==========================================
    // Carriers
    typedef struct packed {
        logic signed [17:0] first;
        logic signed [17:0] second;
    } sample_s;
    typedef struct packed {
        logic ccw;
        logic signed [31:0] torque;
    } cmd_s;
endpackage : torque_cond_pkg

/* rtl/cmd_fifo.sv */
// Small synchronous FIFO for finished torque command words.
// Assumes a single clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module cmd_fifo #(
    parameter int WIDTH = 33,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);
    if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
        $error("cmd_fifo depth must be a power of two of at least 2");
    end
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [PW-1:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
    logic [PW:0] cnt_ff, nxt_cnt;
    logic push, pop;
    // ==========================================
    // Pointers and count
    always_comb begin
        in_ready = cnt_ff != (PW+1)'(DEPTH);
        out_valid = cnt_ff != '0;
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        nxt_wr = push ? wr_ff + 1'b1 : wr_ff;
        nxt_rd = pop ? rd_ff + 1'b1 : rd_ff;
        nxt_cnt = cnt_ff + (PW+1)'(push) - (PW+1)'(pop);
        out_data = mem_ff[rd_ff];
    end
    always_ff @(posedge clk) begin
        if (!nrst) begin
            wr_ff <= '0;
            rd_ff <= '0;
            cnt_ff <= '0;
        end else begin
            wr_ff <= nxt_wr;
            rd_ff <= nxt_rd;
            cnt_ff <= nxt_cnt;
        end
    end
    // Storage holds no reset; only counted entries are ever read out
    always_ff @(posedge clk) begin
        if (push) begin
            mem_ff[wr_ff] <= in_data;
        end
    end
endmodule : cmd_fifo
`default_nettype wire

/* rtl/torque_command_conditioning.sv */
// Torque command conditioning: analog chain, source mux, direction.
// Assumes samples and parameter writes arrive on CORE_CLK; DI terminals are async.
// Contract
// RQ1 - Average filter each channel, zero passes through
// RQ2 - Filter precedes drift and deadband stages
// RQ3 - Subtract signed zero drift after filter
// RQ4 - Apply offset after zero drift correction
// RQ5 - Zero sample inside offset plus-minus deadband
// RQ6 - Scale by full-scale torque over 10 V
// RQ7 - Valid processed span is plus-minus 10 V
// RQ8 - Auto zero-drift calibration per channel setting
// RQ9 - Monitor first channel sample and torque
// RQ10 - Second channel uses same chain, own set
// RQ11 - Auxiliary command B selected like A
// RQ12 - Source 3 switches A/B on DI
// RQ13 - Source 4 takes communication torque value
// RQ14 - Direction DI reverses command sign
// RQ15 - Rotation follows three-way direction parity
// RQ16 - Decode torque source selection codes
// RQ17 - Decode main source selection codes
// RQ18 - Internal setting is 0.1 % signed
// RQ19 - Saturate arithmetic instead of wrapping; the 32-bit full-scale product can still wrap before its limit
// RQ20 - New values next sample, stop-only guarded
`timescale 1ns/1ps
`default_nettype none
module torque_command_conditioning #(
    parameter int SAMPLE_PERIOD_10US = 5,
    parameter int FIFO_DEPTH = torque_cond_pkg::FIFO_WORDS
) (
    input wire logic CORE_CLK,
    input wire logic NRST,
    input wire logic RUNNING,
    input wire logic PARAM_WE,
    input wire logic [3:0] PARAM_ADDR,
    input wire logic [31:0] PARAM_WDATA,
    input wire logic [3:0] PARAM_RADDR,
    output logic [31:0] PARAM_RDATA,
    input wire logic SAMPLE_VALID,
    output logic SAMPLE_READY,
    input wire torque_cond_pkg::sample_s SAMPLE,
    input wire logic SOURCE_SWITCH_INPUT,
    input wire logic DIRECTION_INVERT_INPUT,
    output logic CMD_VALID,
    input wire logic CMD_READY,
    output torque_cond_pkg::cmd_s CMD,
    output logic [31:0] AI_FIRST_SAMPLE_MONITOR,
    output logic [31:0] ANALOG_TORQUE_MONITOR
);
    import torque_cond_pkg::*;
    if (SAMPLE_PERIOD_10US < 1 || FIFO_DEPTH < 2) begin : g_bad_param
        $error("sample period and fifo depth must be positive");
    end

    // ==========================================
    // Arithmetic helpers
    function automatic logic signed [31:0] sx16(input logic [31:0] v);
        return {{16{v[15]}}, v[15:0]};
    endfunction : sx16

    function automatic logic signed [31:0] sat(input logic signed [31:0] v,
                                               input logic signed [31:0] lim);
        if (v > lim) return lim;
        if (v < -lim) return -lim;
        return v;
    endfunction : sat

    // Power-of-two approximation of the averaging time keeps the
    // filter multiplier-free; ratio at or below one passes through.
    function automatic logic [3:0] shift_of(input logic [31:0] tau);
        logic [15:0] r;
        logic [3:0] s;
        r = 16'(tau[15:0] / 16'(SAMPLE_PERIOD_10US));
        s = '0;
        for (int i = 1; i < 16; i++) begin
            if (r[i]) s = 4'(i);
        end
        return s;
    endfunction : shift_of

    // ==========================================
    // Input synchronisers for the DI terminals
    logic [1:0] di_meta_ff, di_ff, nxt_meta;
    logic src_sw, dir_inv;
    always_comb begin
        nxt_meta = {DIRECTION_INVERT_INPUT, SOURCE_SWITCH_INPUT};
        src_sw = di_ff[0];
        dir_inv = di_ff[1];
    end
    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            di_meta_ff <= '0;
            di_ff <= '0;
        end else begin
            di_meta_ff <= nxt_meta;
            di_ff <= di_meta_ff;
        end
    end

    // ==========================================
    // Sample pipeline and per-channel filter
    logic valid_ff, nxt_valid, accept, push, fifo_ready;
    logic signed [31:0] filt_ff [N_CH];
    logic signed [31:0] nxt_filt [N_CH];
    logic signed [31:0] y4 [N_CH];
    logic signed [31:0] y5 [N_CH];
    logic signed [31:0] an_torque [N_CH];
    logic [31:0] regs_ff [N_REGS];
    logic [3:0] shift [N_CH];

    always_comb begin
        SAMPLE_READY = !valid_ff || fifo_ready;
        accept = SAMPLE_VALID && SAMPLE_READY;
        push = valid_ff && fifo_ready;
        nxt_valid = accept || (valid_ff && !push);
    end
    always_ff @(posedge CORE_CLK) begin
        if (!NRST) valid_ff <= 1'b0;
        else valid_ff <= nxt_valid;
    end

    // RQ10 same chain per channel
    for (genvar c = 0; c < N_CH; c++) begin : g_ch
        localparam logic [3:0] B = 4'(c) * CH_STRIDE;
        logic signed [31:0] x, y3, db;
        always_comb begin
            x = (c == 0) ? 32'(SAMPLE.first) : 32'(SAMPLE.second);
            shift[c] = shift_of(regs_ff[B + CH_FILTER]);
            nxt_filt[c] = filt_ff[c];
            // RQ1 averaging filter
            if (accept) begin
                nxt_filt[c] = (shift[c] == '0) ? x
                            : filt_ff[c] + ((x - filt_ff[c]) >>> shift[c]);
            end
            // RQ2 filter output feeds drift stage
            // RQ3 zero drift subtraction
            y3 = filt_ff[c] - sx16(regs_ff[B + CH_ZERO_DRIFT]);
            // RQ4 offset after drift; RQ7 span limit; RQ19 saturation
            y4[c] = sat(y3 - sx16(regs_ff[B + CH_OFFSET]) * OFFSET_TO_TENTH,
                        SPAN_LIMIT);
            db = 32'(regs_ff[B + CH_DEADBAND][15:0]);
            // RQ5 deadband
            y5[c] = (y4[c] <= db && y4[c] >= -db) ? '0 : y4[c];
            // RQ6 full-scale scaling
            // Signed product keeps negative voltages negative
            an_torque[c] = sat(y5[c] * $signed(32'(regs_ff[REG_FULL_SCALE][15:0]))
                               / TORQUE_DIV, TORQUE_LIMIT);
        end
        always_ff @(posedge CORE_CLK) begin
            if (!NRST) filt_ff[c] <= '0;
            else filt_ff[c] <= nxt_filt[c];
        end
    end

    // ==========================================
    // Source selection and direction
    logic signed [31:0] cmd_a, cmd_b, pre_dir, internal_t;
    logic [2:0] tsrc;
    cmd_s word;

    function automatic logic signed [31:0] pick(input logic [31:0] code,
                                                input logic signed [31:0] a1,
                                                input logic signed [31:0] a2,
                                                input logic signed [31:0] it);
        // RQ17 main source decode
        if (code[1:0] == SEL_FIRST) return a1;
        if (code[1:0] == SEL_SECOND) return a2;
        return it;
    endfunction : pick

    always_comb begin
        // RQ18 internal setting in 0.1 %
        internal_t = sx16(regs_ff[REG_INTERNAL]) * INTERNAL_TO_MILLI;
        cmd_a = pick(regs_ff[REG_MAIN_SRC], an_torque[0], an_torque[1],
                     internal_t);
        // RQ11 auxiliary B uses same options
        cmd_b = pick(regs_ff[REG_AUX_SRC], an_torque[0], an_torque[1],
                     internal_t);
        tsrc = regs_ff[REG_TORQUE_SRC][2:0];
        // RQ16 torque source decode
        unique case (tsrc)
            SRC_AUX: pre_dir = cmd_b;
            SRC_SUM: pre_dir = sat(cmd_a + cmd_b, TORQUE_LIMIT);
            // RQ12 DI switches A/B
            SRC_SWITCH: pre_dir = src_sw ? cmd_b : cmd_a;
            // RQ13 communication value
            SRC_COMM: pre_dir = sat(regs_ff[REG_COMM_TORQUE], TORQUE_LIMIT);
            default: pre_dir = cmd_a;
        endcase
        // RQ14 sign reversal on DI
        word.torque = dir_inv ? -pre_dir : pre_dir;
        // RQ15 parity of setting, sign and DI
        word.ccw = ~(regs_ff[REG_ROT_DIR][0] ^ pre_dir[31] ^ dir_inv);
    end

    // Back-pressure from the fifo stalls the sampler through SAMPLE_READY
    cmd_fifo #(
        .WIDTH($bits(cmd_s)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(CORE_CLK),
        .nrst(NRST),
        .in_valid(valid_ff),
        .in_ready(fifo_ready),
        .in_data(word),
        .out_valid(CMD_VALID),
        .out_ready(CMD_READY),
        .out_data(CMD)
    );

    // ==========================================
    // Parameter store, calibration and read port
    logic [31:0] nxt_regs [N_REGS];
    logic [31:0] nxt_rdata, nxt_smon, nxt_tmon;
    logic [1:0] cal;
    logic [3:0] cal_idx;
    always_comb begin
        nxt_regs = regs_ff;
        cal = regs_ff[REG_AUTO_CAL][1:0];
        cal_idx = (cal == CAL_SECOND) ? CH_STRIDE + CH_ZERO_DRIFT
                                      : CH_ZERO_DRIFT;
        // RQ8 drift capture while stopped, one shot
        if (push && !RUNNING && (cal == CAL_FIRST || cal == CAL_SECOND)) begin
            nxt_regs[cal_idx] = sat(filt_ff[cal_idx[2]], DRIFT_LIMIT);
            nxt_regs[REG_AUTO_CAL] = '0;
        end
        // RQ20 stop-only entries refused while running
        if (PARAM_WE && !(STOP_ONLY_MASK[PARAM_ADDR] && RUNNING)) begin
            nxt_regs[PARAM_ADDR] = PARAM_WDATA;
        end
        nxt_rdata = regs_ff[PARAM_RADDR];
        // RQ9 live monitors
        nxt_smon = push ? y5[0] : AI_FIRST_SAMPLE_MONITOR;
        nxt_tmon = push ? an_torque[0] : ANALOG_TORQUE_MONITOR;
    end
    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            for (int i = 0; i < N_REGS; i++) regs_ff[i] <= REG_RESET[i];
            PARAM_RDATA <= '0;
            AI_FIRST_SAMPLE_MONITOR <= '0;
            ANALOG_TORQUE_MONITOR <= '0;
        end else begin
            regs_ff <= nxt_regs;
            PARAM_RDATA <= nxt_rdata;
            AI_FIRST_SAMPLE_MONITOR <= nxt_smon;
            ANALOG_TORQUE_MONITOR <= nxt_tmon;
        end
    end

    // ==========================================
    // Checks
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!NRST);

    filter_pass_a: assert property ( // RQ1
        accept && shift[0] == '0 |=> filt_ff[0] == $past(32'(SAMPLE.first)))
        else $error("zero filter time did not pass sample");
    deadband_zero_a: assert property ( // RQ5
        y4[0] <= $signed(32'(regs_ff[CH_DEADBAND][15:0]))
        && y4[0] >= -$signed(32'(regs_ff[CH_DEADBAND][15:0])) |-> an_torque[0] == '0)
        else $error("deadband did not zero command");
    span_limit_a: assert property ( // RQ7
        y4[1] <= SPAN_LIMIT && y4[1] >= -SPAN_LIMIT)
        else $error("processed sample left valid span");
    ab_switch_a: assert property ( // RQ12
        push && tsrc == SRC_SWITCH |-> pre_dir == (src_sw ? cmd_b : cmd_a))
        else $error("DI switch picked wrong command");
    comm_sign_a: assert property ( // RQ14
        push && tsrc == SRC_COMM && dir_inv
        |-> word.torque == -sat(regs_ff[REG_COMM_TORQUE], TORQUE_LIMIT))
        else $error("direction DI did not reverse sign");
    rot_parity_a: assert property ( // RQ15
        push && regs_ff[REG_ROT_DIR][0] == 1'b0 && !dir_inv && pre_dir > 0
        |-> word.ccw)
        else $error("anticlockwise case not produced");
    monitor_upd_a: assert property ( // RQ9
        push |=> ANALOG_TORQUE_MONITOR == $past(an_torque[0])
                 && AI_FIRST_SAMPLE_MONITOR == $past(y5[0]))
        else $error("monitor not refreshed on sample");
    stop_guard_a: assert property ( // RQ20
        PARAM_WE && RUNNING && PARAM_ADDR == REG_TORQUE_SRC
        |=> $stable(regs_ff[REG_TORQUE_SRC]))
        else $error("stop-only entry changed while running");
    cal_done_a: assert property ( // RQ8
        push && !RUNNING && cal == CAL_FIRST && !PARAM_WE
        |=> regs_ff[REG_AUTO_CAL] == '0
            && regs_ff[CH_ZERO_DRIFT] == $past(sat(filt_ff[0], DRIFT_LIMIT)))
        else $error("calibration request not cleared");
    sum_cover_c: cover property (push && tsrc == SRC_SUM);
    full_cover_c: cover property (valid_ff && !fifo_ready ##1 SAMPLE_VALID);
    cal_cover_c: cover property (push && !RUNNING && cal == CAL_SECOND);
endmodule : torque_command_conditioning
`default_nettype wire

/* verif/host_model.sv */
// Host-side model: analog sampler feeding samples, command consumer.
// Assumes the block's clock; the bench drives stall to slow the consumer.
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input wire logic clk,
    input wire logic stall,
    input wire logic sample_ready,
    output logic sample_valid,
    output var torque_cond_pkg::sample_s sample,
    output logic cmd_ready
);
    import torque_cond_pkg::*;
    initial begin
        sample_valid = 1'b0;
        sample = '0;
        cmd_ready = 1'b1;
    end
    // ==========================================
    // Consumer, prompt or slow
    always @(posedge clk) begin
        cmd_ready <= !stall;
    end
    // ==========================================
    // Sampler, holds the pair until taken
    task automatic send(input sample_s s);
        @(posedge clk);
        sample_valid <= 1'b1;
        sample <= s;
        @(posedge clk);
        while (!sample_ready) @(posedge clk);
        // Released lines change so a stale pair cannot pass for valid
        sample_valid <= 1'b0;
        sample <= ~s;
    endtask : send
endmodule : host_model
`default_nettype wire

/* verif/tb.sv */
// Self-checking bench for the torque command conditioning block.
// Assumes the package constants and the host model beside it.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import torque_cond_pkg::*;
    typedef struct {cmd_s cmd; logic [31:0] m1; logic [31:0] m2; bit mon;} note_t;
    logic core_clk, nrst, running, param_we, sample_valid, sample_ready;
    logic sw_in, dir_in, cmd_valid, cmd_ready, stall;
    logic [3:0] param_addr, param_raddr;
    logic [31:0] param_wdata, param_rdata, mon_sample, mon_torque;
    sample_s sample;
    cmd_s cmd;
    logic [31:0] shadow [N_REGS];
    note_t notes [$];
    int n_errors = 0;
    int tests_run = 0;
    int cycles = 0;
    integer seed = 32'h6ac2dd60;
    bit mon_ok;
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    torque_command_conditioning i_torque_command_conditioning (
        .CORE_CLK(core_clk), .NRST(nrst), .RUNNING(running), .PARAM_WE(param_we),
        .PARAM_ADDR(param_addr), .PARAM_WDATA(param_wdata), .PARAM_RADDR(param_raddr),
        .PARAM_RDATA(param_rdata), .SAMPLE_VALID(sample_valid), .SAMPLE_READY(sample_ready),
        .SAMPLE(sample), .SOURCE_SWITCH_INPUT(sw_in), .DIRECTION_INVERT_INPUT(dir_in),
        .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .CMD(cmd),
        .AI_FIRST_SAMPLE_MONITOR(mon_sample), .ANALOG_TORQUE_MONITOR(mon_torque));
    host_model i_host_model (.clk(core_clk), .stall(stall), .sample_ready(sample_ready),
        .sample_valid(sample_valid), .sample(sample), .cmd_ready(cmd_ready));
    // ==========================================
    // Checking and reference arithmetic
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic close_out();
        $display("Checks %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : close_out
    function automatic int rnd(input int m);
        return $random(seed) % (m + 1);
    endfunction : rnd
    function automatic longint sx(input logic [31:0] w);
        return longint'($signed(w[15:0]));
    endfunction : sx
    function automatic longint sat(input longint v, input longint lim);
        return (v > lim) ? lim : ((v < -lim) ? -lim : v);
    endfunction : sat
    function automatic void chain(input int b, input longint x, output longint y5,
                                  output longint t);
        longint y4;
        y4 = sat(x - sx(shadow[b + 3]) - sx(shadow[b]) * 10, 100000);
        y5 = (y4 <= sx(shadow[b + 2]) && y4 >= -sx(shadow[b + 2])) ? 0 : y4;
        t = sat(y5 * sx(shadow[REG_FULL_SCALE]) / 100, 800000);
    endfunction : chain
    function automatic longint pick(input logic [1:0] s, input longint t1, input longint t2);
        return (s == SEL_FIRST) ? t1 : ((s == SEL_SECOND) ? t2 : sx(shadow[REG_INTERNAL]) * 100);
    endfunction : pick
    // ==========================================
    // Drivers
    task automatic wr(input logic [3:0] a, input int v);
        @(posedge core_clk);
        param_we <= 1'b1;
        param_addr <= a;
        param_wdata <= v;
        if (!running || !STOP_ONLY_MASK[a]) shadow[a] = v;
        @(posedge core_clk);
        param_we <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a);
        @(posedge core_clk);
        param_raddr <= a;
        repeat (2) @(posedge core_clk);
        check("param entry", param_rdata, shadow[a]);
    endtask : rd
    task automatic push(input longint x1, input longint x2);
        longint y1, y2, t1, t2, a, b, s;
        sample_s smp;
        note_t n;
        chain(0, x1, y1, t1);
        chain(4, x2, y2, t2);
        a = pick(shadow[REG_MAIN_SRC][1:0], t1, t2);
        b = pick(shadow[REG_AUX_SRC][1:0], t1, t2);
        case (shadow[REG_TORQUE_SRC][2:0])
            SRC_AUX: s = b;
            SRC_SUM: s = sat(a + b, 800000);
            SRC_SWITCH: s = sw_in ? b : a;
            SRC_COMM: s = sat(longint'($signed(shadow[REG_COMM_TORQUE])), 800000);
            default: s = a;
        endcase
        n.cmd.torque = 32'(dir_in ? -s : s);
        n.cmd.ccw = ~(shadow[REG_ROT_DIR][0] ^ (s < 0) ^ dir_in);
        n.m1 = 32'(y1);
        n.m2 = 32'(t1);
        n.mon = mon_ok;
        notes.push_back(n);
        smp.first = 18'(x1);
        smp.second = 18'(x2);
        i_host_model.send(smp);
    endtask : push
    // ==========================================
    // Output watcher and hang guard
    always @(posedge core_clk) begin : watch
        note_t n;
        cycles <= cycles + 1;
        if (cmd_valid === 1'b1 && cmd_ready) begin
            if (notes.size() == 0) begin
                check("unexpected command", 64'h1, 64'h0);
            end else begin
                n = notes.pop_front();
                check("command", cmd, n.cmd);
                if (n.mon) check("sample monitor", mon_sample, n.m1);
                if (n.mon) check("torque monitor", mon_torque, n.m2);
            end
        end
        if (cycles == 40000) begin
            n_errors++;
            close_out();
        end
    end
    // ==========================================
    // Main sequence
    initial begin
        nrst = 1'b0;
        running = 1'b0;
        param_we = 1'b0;
        param_addr = '0;
        param_wdata = '0;
        param_raddr = '0;
        sw_in = 1'b0;
        dir_in = 1'b0;
        stall = 1'b0;
        mon_ok = 1'b1;
        foreach (shadow[i]) shadow[i] = REG_RESET[i];
        repeat (6) @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk);
        check("idle valid", cmd_valid, 64'h0);
        check("idle ready", sample_ready, 64'h1);
        for (int a = 0; a < N_REGS; a++) rd(4'(a));
        wr(CH_FILTER, 0);
        wr(CH_STRIDE + CH_FILTER, 0);
        for (int i = 0; i < 40; i++) begin
            for (int c = 0; c < 8; c += 4) begin
                wr(4'(c) + CH_OFFSET, rnd(5000));
                wr(4'(c) + CH_ZERO_DRIFT, rnd(5000));
                wr(4'(c) + CH_DEADBAND, (i % 9) * 1250);
            end
            wr(REG_FULL_SCALE, 450 + rnd(350));
            wr(REG_TORQUE_SRC, i % 8);
            wr(REG_MAIN_SRC, i % 4);
            wr(REG_AUX_SRC, (i / 4) % 4);
            wr(REG_INTERNAL, rnd(3000));
            wr(REG_ROT_DIR, (i / 2) % 2);
            wr(REG_COMM_TORQUE, rnd(100000));
            sw_in <= 1'($random(seed));
            dir_in <= 1'($random(seed));
            repeat (4) @(posedge core_clk);
            push(rnd(100000), rnd(100000));
            push(sx(shadow[3]) + sx(shadow[0]) * 10 + sx(shadow[2]) + i % 2, rnd(100000));
        end
        running <= 1'b1;
        for (int a = 8; a < N_REGS; a++) begin
            wr(4'(a), 5);
            rd(4'(a));
        end
        wr(CH_OFFSET, 7);
        rd(CH_OFFSET);
        running <= 1'b0;
        // Calibration alters drift under the monitors, so those are skipped here
        mon_ok = 1'b0;
        wr(REG_TORQUE_SRC, SRC_COMM);
        wr(REG_AUTO_CAL, CAL_FIRST);
        push(300, 0);
        shadow[CH_ZERO_DRIFT] = 300;
        shadow[REG_AUTO_CAL] = 0;
        rd(CH_ZERO_DRIFT);
        rd(REG_AUTO_CAL);
        wr(REG_AUTO_CAL, CAL_SECOND);
        push(0, 90000);
        shadow[CH_STRIDE + CH_ZERO_DRIFT] = 5000;
        shadow[REG_AUTO_CAL] = 0;
        rd(CH_STRIDE + CH_ZERO_DRIFT);
        wr(REG_MAIN_SRC, SEL_FIRST);
        wr(REG_TORQUE_SRC, SRC_MAIN);
        stall <= 1'b1;
        repeat (5) push(rnd(100000), 0);
        repeat (2) @(posedge core_clk);
        check("full ready", sample_ready, 64'h0);
        fork
            repeat (6) push(rnd(100000), 0);
            repeat (90) @(posedge core_clk) stall <= 1'($random(seed));
        join
        stall <= 1'b0;
        repeat (30) @(posedge core_clk);
        check("drained", cmd_valid, 64'h0);
        check("pending notes", 64'(notes.size()), 64'h0);
        close_out();
    end
endmodule : tb
`default_nettype wire
